// >>> rtl/eac_core.sv
// Exposure sequencing, overtrigger detection, status selection and output line routing.
`timescale 1ns/10ps
`include "eac_defs.svh"

// Overview of operation
// - Programmed duration used for trigger off, software source, or line 1/2 timed.
// - Duration setting counts in whole microseconds, step of one.
// - Duration clamped to 12 us (18 us variant) up to 2500000 us.
// - Manual duration governs only while auto exposure is disabled.
// - Auto adjustment is disabled after power on or reset.
// - Non-overlapped: exposure and readout finish before next frame starts.
// - Overlap when frame period at most exposure plus readout time.
// - Readable readout time in microseconds is reported.
// - Exposure-active output high during exposure, lagging slightly.
// - Exposure-active routable to any output line 1 to 4.
// - Software acquisition start outside waiting state ignored, overtrigger raised.
// - Software frame start outside waiting state ignored, overtrigger raised.
// - Selector picks acquisition or frame trigger waiting flag as status.
// - Status reads true while waiting for selected trigger.
// - Timed mode starts exposure on selected edge, ends after duration.
// - Frame wait asserted entering wait state, cleared on accepted trigger.
module eac_core #(
	parameter int          EXP_W    = 22,
	parameter int          TICK_DIV = `EAC_CLK_MHZ,
	parameter logic [21:0] RO_US    = 22'h0003E8
) (
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire logic             acq_enable,
	input  wire logic             fs_trig_mode_on,
	input  wire logic [1:0]       fs_trig_source,
	input  wire logic             exp_mode_timed,
	input  wire logic             trig_rising,
	input  wire logic             alt_sensor,
	input  wire logic             auto_exp_req,
	input  wire logic [EXP_W-1:0] exposure_us,
	input  wire logic [1:0]       exp_line_sel,
	input  wire logic             status_sel_frame,
	input  wire logic             sw_acq_start,
	input  wire logic             sw_frame_start,
	input  wire logic             ext_frame_begin_pulse,
	output logic [3:0]            out_lines,
	output logic                  acq_status,
	output logic                  frame_trig_wait,
	output logic                  acq_trig_wait,
	output logic                  acq_overtrig,
	output logic                  frame_overtrig,
	output logic                  exp_overlapped,
	output logic                  auto_exp_active,
	output logic [EXP_W-1:0]      readout_time_us
);

	// ----------------------------------------------------------------
	// State and registers
	// ----------------------------------------------------------------
	// The divider width follows the clock ratio, so another clock rate needs no edit here.
	localparam int TICK_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
	// Readout length at the counter width; the parameter keeps its published width.
	localparam logic [EXP_W-1:0] RO_LEN = EXP_W'(RO_US);
	eac_pkg::eac_state_e state_ff, nxt_state;
	logic [EXP_W-1:0] exp_cnt_ff, ro_cnt_ff, period_ff, exp_len_ff;
	logic [TICK_W-1:0] tick_cnt_ff;
	logic             ext_d_ff, shutter_ff, auto_ff;
	logic             ovr_acq_ff, ovr_frm_ff, ovl_ff;
	logic [3:0]       lines_ff;
	logic             shutter_open_indicator;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Microsecond tick; the divider trades precision for a tiny counter.
	wire tick_us = (tick_cnt_ff == TICK_W'(TICK_DIV - 1));
	wire [TICK_W-1:0] nxt_tick_cnt = tick_us ? '0 : tick_cnt_ff + TICK_W'(1);
	wire [EXP_W-1:0] exp_min = alt_sensor ? `EAC_EXP_MIN_ALT_US : `EAC_EXP_MIN_US;
	// Clamp into the legal range so a bad host value cannot stall the shutter.
	wire [EXP_W-1:0] exp_clamped = (exposure_us < exp_min) ? exp_min :
		(exposure_us > `EAC_EXP_MAX_US) ? `EAC_EXP_MAX_US : exposure_us;
	wire hw_src = (fs_trig_source == `EAC_SRC_LINE1) || (fs_trig_source == `EAC_SRC_LINE2);
	wire use_prog = !fs_trig_mode_on || (fs_trig_source == `EAC_SRC_SOFT) ||
		(hw_src && exp_mode_timed);
	wire ext_edge = trig_rising ? (ext_frame_begin_pulse && !ext_d_ff)
		: (!ext_frame_begin_pulse && ext_d_ff);
	wire fs_hw_evt = fs_trig_mode_on && hw_src && ext_edge;
	wire fs_sw_evt = fs_trig_mode_on && (fs_trig_source == `EAC_SRC_SOFT) && sw_frame_start;
	wire fs_evt = !fs_trig_mode_on || fs_hw_evt || fs_sw_evt;
	wire in_wait_fs = (state_ff == eac_pkg::EAC_WAIT_FS);
	wire ro_busy = (ro_cnt_ff != '0);
	// The next exposure always waits for readout to drain; no start is allowed during readout.
	wire can_start = in_wait_fs && fs_evt && !ro_busy;
	wire exp_done = (state_ff == eac_pkg::EAC_EXPOSE) && tick_us && (exp_cnt_ff >= exp_len_ff - 1'b1);
	wire width_end = (state_ff == eac_pkg::EAC_EXPOSE) && !use_prog &&
		(trig_rising ? !ext_frame_begin_pulse : ext_frame_begin_pulse);
	wire exp_end = use_prog ? exp_done : width_end;
	// Auto exposure only runs when requested; manual time is valid otherwise.
	wire manual_ok = !auto_ff;

	// ----------------------------------------------------------------
	// Counter next values
	// ----------------------------------------------------------------
	// The exposure counter restarts at each accepted trigger and moves on the tick.
	wire [EXP_W-1:0] nxt_exp_cnt = can_start ? '0 :
		(tick_us ? exp_cnt_ff + 1'b1 : exp_cnt_ff);
	// While auto exposure owns the time, a start keeps the last manual length.
	wire [EXP_W-1:0] nxt_exp_len = (can_start && manual_ok) ? exp_clamped : exp_len_ff;
	// The period counter saturates so a long pause never wraps into a false overlap.
	wire period_sat = (period_ff == '1);
	wire [EXP_W-1:0] nxt_period = can_start ? '0 :
		((tick_us && !period_sat) ? period_ff + 1'b1 : period_ff);
	// Readout is loaded at the end of exposure and drains one count per microsecond.
	wire [EXP_W-1:0] nxt_ro_cnt = exp_end ? RO_LEN :
		((tick_us && ro_busy) ? ro_cnt_ff - 1'b1 : ro_cnt_ff);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			eac_pkg::EAC_IDLE:    if (acq_enable && sw_acq_start) nxt_state = eac_pkg::EAC_WAIT_FS;
			eac_pkg::EAC_WAIT_FS: begin
				if (!acq_enable) nxt_state = eac_pkg::EAC_IDLE;
				else if (can_start) nxt_state = eac_pkg::EAC_EXPOSE;
			end
			eac_pkg::EAC_EXPOSE:  if (exp_end) nxt_state = eac_pkg::EAC_WAIT_FS;
			default:              nxt_state = eac_pkg::EAC_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer registers
	// ----------------------------------------------------------------
	// State register of the frame sequencer.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= eac_pkg::EAC_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Free-running microsecond divider; its phase is not tied to the trigger,
	// so a timed exposure may end up to one microsecond before the full setting.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tick_cnt_ff <= '0;
		end else begin
			tick_cnt_ff <= nxt_tick_cnt;
		end
	end

	// Input history for the edge detector and the registered auto request.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ext_d_ff <= 1'b0;
			auto_ff  <= 1'b0;
		end else begin
			ext_d_ff <= ext_frame_begin_pulse;
			auto_ff  <= auto_exp_req;
		end
	end

	// Exposure length and elapsed time of the current frame.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			exp_cnt_ff <= '0;
			exp_len_ff <= EXP_W'(`EAC_EXP_MIN_US);
		end else begin
			exp_cnt_ff <= nxt_exp_cnt;
			exp_len_ff <= nxt_exp_len;
		end
	end

	// The period starts saturated, so the first frame after reset never reads as overlapped.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			period_ff <= '1;
			ro_cnt_ff <= '0;
		end else begin
			period_ff <= nxt_period;
			ro_cnt_ff <= nxt_ro_cnt;
		end
	end

	// ----------------------------------------------------------------
	// Status, events and output lines
	// ----------------------------------------------------------------
	assign shutter_open_indicator = (state_ff == eac_pkg::EAC_EXPOSE);
	wire ovr_acq = sw_acq_start && (state_ff != eac_pkg::EAC_IDLE);
	wire ovr_frm = fs_trig_mode_on && (fs_sw_evt || fs_hw_evt) && !can_start;
	wire ovl_now = can_start && (period_ff <= exp_len_ff + RO_LEN);
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_line
			always_ff @(posedge clock or negedge arst_n) begin
				if (!arst_n) lines_ff[gi] <= 1'b0;
				else lines_ff[gi] <= shutter_ff && (exp_line_sel == 2'(gi));
			end
		end
	endgenerate

	// The register stage gives the indicator its short lag behind the exposure state.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			shutter_ff <= 1'b0;
		end else begin
			shutter_ff <= shutter_open_indicator;
		end
	end

	// Overtrigger events are one-cycle pulses; the overlap flag holds until the next start.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ovr_acq_ff <= 1'b0;
			ovr_frm_ff <= 1'b0;
			ovl_ff     <= 1'b0;
		end else begin
			ovr_acq_ff <= ovr_acq;
			ovr_frm_ff <= ovr_frm;
			if (can_start) ovl_ff <= ovl_now;
		end
	end

	assign out_lines       = lines_ff;
	assign frame_trig_wait = in_wait_fs;
	assign acq_trig_wait   = (state_ff == eac_pkg::EAC_IDLE);
	assign acq_status      = status_sel_frame ? frame_trig_wait : acq_trig_wait;
	assign acq_overtrig    = ovr_acq_ff;
	assign frame_overtrig  = ovr_frm_ff;
	assign exp_overlapped  = ovl_ff;
	assign auto_exp_active = auto_ff;
	assign readout_time_us = RO_LEN;

endmodule : eac_core

// >>> rtl/eac_defs.svh
// Constants for the exposure acquisition control block.
`ifndef EAC_DEFS_SVH
`define EAC_DEFS_SVH
`define EAC_CLK_MHZ        20
`define EAC_EXP_MIN_US     22'h00000C
`define EAC_EXP_MIN_ALT_US 22'h000012
`define EAC_EXP_MAX_US     22'h2625A0
`define EAC_SRC_SOFT       2'h0
`define EAC_SRC_LINE1      2'h1
`define EAC_SRC_LINE2      2'h2
`define EAC_LINE_OUT1      2'h0
`define EAC_LINE_OUT2      2'h1
`define EAC_LINE_OUT3      2'h2
`define EAC_LINE_OUT4      2'h3
`endif

// >>> rtl/eac_pkg.sv
// Types for the exposure acquisition control block.
package eac_pkg;
	typedef enum logic [1:0] {
		EAC_IDLE    = 2'b00,
		EAC_WAIT_FS = 2'b01,
		EAC_EXPOSE  = 2'b10
	} eac_state_e;
endpackage : eac_pkg

// >>> tb/eac_core_properties.sv
// Port checker for the exposure acquisition control block.
`timescale 1ns/10ps
module eac_chk #(parameter logic [21:0] RO_US = 22'h0003E8) (
	input wire logic        clock, arst_n, sw_acq_start, sw_frame_start, acq_enable, fs_trig_mode_on,
	input wire logic        status_sel_frame, auto_exp_req, acq_status, acq_trig_wait, frame_trig_wait,
	input wire logic        acq_overtrig, frame_overtrig, auto_exp_active,
	input wire logic [1:0]  fs_trig_source, exp_line_sel,
	input wire logic [3:0]  out_lines,
	input wire logic [21:0] readout_time_us
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	logic [15:0] gap_ff;
	// Idle cycles since the last exposure; starts saturated so the first frame is not held back.
	always_ff @(posedge clock or negedge arst_n)
		if (!arst_n) gap_ff <= 16'hFFFF;
		else if (|out_lines) gap_ff <= 16'h0000;
		else if (gap_ff != 16'hFFFF) gap_ff <= gap_ff + 16'h0001;
	chk_acq_refused: assert property (sw_acq_start && !acq_trig_wait |=> acq_overtrig)
		else $error("acq overtrigger missing");
	chk_acq_taken: assert property (sw_acq_start && acq_trig_wait && acq_enable |=> !acq_overtrig && frame_trig_wait)
		else $error("acq start not taken");
	chk_frame_refused: assert property (sw_frame_start && fs_trig_mode_on && fs_trig_source == 2'h0 && !frame_trig_wait
		|=> frame_overtrig) else $error("frame overtrigger missing");
	chk_status_mux: assert property (acq_status == (status_sel_frame ? frame_trig_wait : acq_trig_wait))
		else $error("status selection wrong");
	chk_expose_start: assert property ($fell(frame_trig_wait) && !acq_trig_wait |=> ##1 out_lines != 4'h0)
		else $error("exposure output late");
	chk_line_route: assert property ($rose(|out_lines) |-> out_lines == 4'h1 << $past(exp_line_sel))
		else $error("exposure on wrong line");
	chk_auto_off: assert property (!$past(auto_exp_req) |-> !auto_exp_active)
		else $error("auto exposure active unasked");
	chk_readout_val: assert property (readout_time_us == RO_US)
		else $error("readout time wrong");
	chk_readout_gap: assert property ($rose(|out_lines) |-> gap_ff >= 16'((RO_US - 22'h1) * 20))
		else $error("exposure started during readout");
	cover property (acq_overtrig);
	cover property (frame_overtrig);
	cover property ($rose(|out_lines));
endmodule : eac_chk
bind eac_core eac_chk #(.RO_US(RO_US)) chk_u (.*);

// >>> tb/eac_trig_model.sv
// Trigger equipment model driving the external frame start line.
`timescale 1ns/10ps
module eac_trig_model (
	input  wire logic clock, fire, trig_rising, frame_trig_wait,
	output logic      ext_frame_begin_pulse
);
	logic [1:0] hold_ff = 2'h0;
	// Fires only while the camera waits and holds the level a few cycles, so the edge is never lost.
	always @(posedge clock)
		if (fire && frame_trig_wait) hold_ff <= 2'h3;
		else if (hold_ff != 2'h0) hold_ff <= hold_ff - 2'h1;
	assign ext_frame_begin_pulse = trig_rising ~^ (hold_ff != 2'h0);
endmodule : eac_trig_model

// >>> tb/tb.sv
// Self-checking bench for the exposure acquisition control block.
`timescale 1ns/10ps
`include "eac_defs.svh"
module tb;
	localparam logic [21:0] RO = 22'h000005;
	logic clock = 1'b0, arst_n = 1'b0, acq_enable = 1'b0, fs_trig_mode_on = 1'b1, exp_mode_timed = 1'b1;
	logic trig_rising = 1'b1, alt_sensor = 1'b0, auto_exp_req = 1'b0, status_sel_frame = 1'b0, fire = 1'b0;
	logic sw_acq_start = 1'b0, sw_frame_start = 1'b0, ext_frame_begin_pulse, acq_status, frame_trig_wait;
	logic acq_trig_wait, acq_overtrig, frame_overtrig, exp_overlapped, auto_exp_active;
	logic [1:0] fs_trig_source = 2'h0, exp_line_sel = 2'h0;
	logic [3:0] out_lines;
	logic [21:0] exposure_us = 22'h00000C, readout_time_us;
	int error_cnt = 0, cmp_count = 0, n, len;
	eac_core #(.RO_US(RO)) dut_u (.*);
	eac_trig_model tm_u (.clock, .fire, .trig_rising, .frame_trig_wait, .ext_frame_begin_pulse);
	always #25 clock = ~clock;
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		cmp_count++;
		if (e !== g) begin
			error_cnt++;
			$display("unexpected %s: expected %0d, seen %0d", nm, e, g);
		end
	endtask : chk
	task automatic test_done();
		$display("compares %0d, errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done
	// Exposure length in clocks; short settings are raised to the sensor minimum.
	function automatic int exp_len(input logic [21:0] us, input logic a);
		logic [21:0] lo;
		lo = a ? `EAC_EXP_MIN_ALT_US : `EAC_EXP_MIN_US;
		return `EAC_CLK_MHZ * int'((us < lo) ? lo : us);
	endfunction : exp_len
	// Watchdog well past the longest expected run.
	initial begin
		#3000000;
		error_cnt++;
		test_done();
	end
	// Reset values, a refused frame start, then random frames through both trigger paths.
	initial begin
		void'($urandom(64941));
		repeat (6) @(negedge clock);
		arst_n = 1'b1;
		chk("acq wait", 1, acq_trig_wait);
		chk("readout", RO, readout_time_us);
		sw_frame_start = 1'b1;
		@(negedge clock) sw_frame_start = 1'b0;
		chk("fs overtrig", 1, frame_overtrig);
		len = exp_len(`EAC_EXP_MIN_US, 1'b0);
		for (int i = 0; i < 20; i++) begin
			exposure_us = 22'($urandom_range(40, 1));
			{alt_sensor, trig_rising, status_sel_frame, auto_exp_req} = 4'($urandom);
			exp_line_sel = 2'($urandom);
			fs_trig_source = (i % 3 == 2) ? 2'h1 : 2'h0;
			fs_trig_mode_on = (i % 5 != 4);
			acq_enable = 1'b1;
			sw_acq_start = 1'b1;
			@(negedge clock) chk("acq overtrig", 0, acq_overtrig);
			@(negedge clock) chk("acq overtrig", 1, acq_overtrig);
			sw_acq_start = 1'b0;
			sw_frame_start = (fs_trig_source == 2'h0);
			fire = (fs_trig_source != 2'h0);
			@(negedge clock) {sw_frame_start, fire} = 2'b00;
			n = 0;
			while (out_lines === 4'h0 && n < 50) @(negedge clock) n++;
			chk("line", 4'h1 << exp_line_sel, out_lines);
			chk("overlap", 0, exp_overlapped);
			n = 0;
			while (out_lines !== 4'h0 && n < 2000) @(negedge clock) begin
				n++;
				sw_frame_start = (n == 5);
			end
			// With auto exposure on, the manual setting is not taken and the last length stays.
			if (!auto_exp_req) len = exp_len(exposure_us, alt_sensor);
			chk("exp len", 1, n >= len - 20 && n <= len + 1);
			chk("frame wait", 1, frame_trig_wait);
			acq_enable = 1'b0;
			repeat (200) @(negedge clock);
		end
		test_done();
	end
endmodule : tb
